// file: logic/wpm_map.svh
// register offsets, field positions and reset values of the watchpoint block
`ifndef WPM_MAP_SVH
`define WPM_MAP_SVH
// address regions, selected by address bits [7:4]
`define WPM_REG_VAL 4'h0
`define WPM_REG_CTL 4'h1
`define WPM_REG_IRQ 4'h2
// words inside the interrupt region, selected by address bits [3:2]
`define WPM_IRQ_STAT 2'h0
`define WPM_IRQ_MASK 2'h1
// control field positions
`define WPM_EN_BIT 0
`define WPM_PRIV_LSB 1
`define WPM_PRIV_MSB 2
`define WPM_TYPE_LSB 3
`define WPM_TYPE_MSB 4
`define WPM_LANE_LSB 5
`define WPM_LANE_MSB 12
`define WPM_HYP_BIT 13
`define WPM_SEC_LSB 14
`define WPM_SEC_MSB 15
`define WPM_LINK_IDX_LSB 16
`define WPM_LINK_IDX_MSB 19
`define WPM_LINK_BIT 20
`define WPM_MSK_LSB 24
`define WPM_MSK_MSB 28
// writable bits and reset values
`define WPM_CTL_WMASK 32'h1f1f_ffff
`define WPM_VAL_WMASK 32'hffff_fffc
`define WPM_CTL_RST 32'h0000_0000
`define WPM_VAL_RST 32'h0000_0000
// smallest mask width that is not reserved
`define WPM_MSK_MIN 5'h03
`endif

// file: logic/wpm_pkg.sv
// types shared by the watchpoint block
`default_nettype none
package wpm_pkg;
  typedef enum logic [1:0] {
    WPM_SEC_ANY = 2'b00,
    WPM_SEC_NS  = 2'b01,
    WPM_SEC_S   = 2'b10,
    WPM_SEC_ALL = 2'b11
  } wpm_sec_e;
  typedef enum logic [1:0] {
    WPM_TYPE_RSV   = 2'b00,
    WPM_TYPE_LOAD  = 2'b01,
    WPM_TYPE_STORE = 2'b10,
    WPM_TYPE_BOTH  = 2'b11
  } wpm_type_e;
endpackage : wpm_pkg
`default_nettype wire

// file: logic/wpm_match.sv
// match logic of one watchpoint pair, with a registered hit
`include "wpm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module wpm_match (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // pair configuration
  input  wire logic [31:0] i_ctl,
  input  wire logic [31:0] i_wvr,
  // data access
  input  wire logic        i_acc_valid,
  input  wire logic [31:0] i_acc_addr,
  input  wire logic [1:0]  i_acc_size,
  input  wire logic        i_acc_load,
  input  wire logic        i_acc_store,
  input  wire logic        i_acc_priv,
  input  wire logic        i_acc_hyp,
  input  wire logic        i_acc_secure,
  input  wire logic [15:0] i_ctx_match,
  // hit
  output logic             o_hit
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  lanes;
  logic [7:0]  byte_hit;
  logic [4:0]  msk;
  logic [31:0] len;
  logic [31:0] hi_mask;
  logic [31:0] acc_last;
  logic        addr_ok;
  logic        sec_ok;
  logic        mode_ok;
  logic        type_ok;
  logic        link_ok;
  logic        next_hit;
  wpm_pkg::wpm_sec_e  sec_sel;
  wpm_pkg::wpm_type_e type_sel;

  assign lanes    = i_ctl[`WPM_LANE_MSB:`WPM_LANE_LSB];
  assign msk      = i_ctl[`WPM_MSK_MSB:`WPM_MSK_LSB];
  assign sec_sel  = wpm_pkg::wpm_sec_e'(i_ctl[`WPM_SEC_MSB:`WPM_SEC_LSB]);
  assign type_sel = wpm_pkg::wpm_type_e'(i_ctl[`WPM_TYPE_MSB:`WPM_TYPE_LSB]);
  assign len      = 32'h1 << i_acc_size;
  assign acc_last = i_acc_addr + len - 32'h1;
  assign hi_mask  = 32'hffff_ffff << msk;

  // modular distance covers wide and word-crossing accesses alike
  for (genvar j = 0; j < 8; j++)
  begin : g_byte
    logic [31:0] off;
    assign off = {i_wvr[31:2], 2'b00} + 32'(j) - i_acc_addr;
    assign byte_hit[j] = lanes[j] && (off < len);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // reserved mask values 1 and 2 fall back to byte lanes
    if (msk >= `WPM_MSK_MIN)
      addr_ok = (((i_acc_addr ^ i_wvr) & hi_mask) == 32'h0) ||
                (((acc_last ^ i_wvr) & hi_mask) == 32'h0);
    else
      addr_ok = |byte_hit;
    case (sec_sel)
      wpm_pkg::WPM_SEC_NS: sec_ok = !i_acc_secure;
      wpm_pkg::WPM_SEC_S:  sec_ok = i_acc_secure;
      default:             sec_ok = 1'b1;
    endcase
    if (i_acc_hyp)
      mode_ok = i_ctl[`WPM_HYP_BIT];
    else if (i_acc_priv)
      mode_ok = i_ctl[`WPM_PRIV_LSB];
    else
      mode_ok = i_ctl[`WPM_PRIV_MSB];
    // swaps raise both load and store, so either filter takes them
    type_ok = (type_sel[0] && i_acc_load) || (type_sel[1] && i_acc_store);
    link_ok = !i_ctl[`WPM_LINK_BIT] ||
              i_ctx_match[i_ctl[`WPM_LINK_IDX_MSB:`WPM_LINK_IDX_LSB]];
    next_hit = i_acc_valid && i_ctl[`WPM_EN_BIT] && addr_ok && sec_ok &&
               mode_ok && type_ok && link_ok;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_hit <= 1'b0;
    else
      o_hit <= next_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_enable_gate;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_ctl[`WPM_EN_BIT] |=> !o_hit;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("hit while disabled");

  property p_type_filter;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_ctl[`WPM_TYPE_MSB:`WPM_TYPE_LSB] == 2'b01) && !i_acc_load |=> !o_hit;
  endproperty
  a_type_filter: assert property (p_type_filter)
    else $error("load-only watchpoint hit a non-load");

  property p_hyp_ctl;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_acc_hyp && !i_ctl[`WPM_HYP_BIT] |=> !o_hit;
  endproperty
  a_hyp_ctl: assert property (p_hyp_ctl)
    else $error("hyp access hit without hyp control");

  property p_link_ctx;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_ctl[`WPM_LINK_BIT] && !i_ctx_match[i_ctl[`WPM_LINK_IDX_MSB:`WPM_LINK_IDX_LSB]]
      |=> !o_hit;
  endproperty
  a_link_ctx: assert property (p_link_ctx)
    else $error("linked hit without context match");

  property p_byte_lane;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_acc_size == 2'h0 && i_acc_addr == {i_wvr[31:2], 2'b00} &&
      !i_ctl[`WPM_LANE_LSB] && msk == 5'h00 |=> !o_hit;
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("hit on unselected byte");

  property p_hit_cause;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_hit |-> $past(i_acc_valid) && $past(i_ctl[`WPM_EN_BIT]);
  endproperty
  a_hit_cause: assert property (p_hit_cause)
    else $error("hit without enabled access");
endmodule : wpm_match
`default_nettype wire

// file: logic/wpm_top.sv
// watchpoint pairs with register file, match units and interrupt
//
// Contract
// - link bit demands address and context match
// - security field qualifies match by security state
// - hyp accesses ignore privilege, use hyp bit
// - byte lanes qualify the word-aligned watch address
// - larger accesses hit when touching watched byte
// - unaligned accesses crossing words still hit
// - access type filters loads, stores or both
// - privilege field qualifies match by processor mode
// - enable bit gates every watchpoint event
// - value register holds bits 31:2, low bits zero
// - mask field drops low address bits from compare
// - four independent control and value pairs
`include "wpm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module wpm_top #(
  parameter int unsigned WP_NUM = 4
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  // avalon-mm slave
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // data access from the load/store pipeline
  input  wire logic              i_acc_valid,
  input  wire logic [31:0]       i_acc_addr,
  input  wire logic [1:0]        i_acc_size,
  input  wire logic              i_acc_load,
  input  wire logic              i_acc_store,
  input  wire logic              i_acc_priv,
  input  wire logic              i_acc_hyp,
  input  wire logic              i_acc_secure,
  // context match per breakpoint
  input  wire logic [15:0]       i_ctx_match,
  // events
  output logic [WP_NUM-1:0]      o_wp_event,
  output logic                   o_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]       watchpoint_control [WP_NUM];
  logic [31:0]       watch_address_value [WP_NUM];
  logic [WP_NUM-1:0] irq_status;
  logic [WP_NUM-1:0] irq_mask;
  logic [WP_NUM-1:0] next_status;
  logic [WP_NUM-1:0] st_clr;
  logic [WP_NUM-1:0] hit;
  logic [31:0]       next_rdata;
  logic              wait_q;
  logic              req;
  logic              acc_wr;
  logic [3:0]        region;
  logic [1:0]        idx;

  assign req    = i_avs_read || i_avs_write;
  assign acc_wr = i_avs_write && !wait_q;
  assign region = i_avs_address[7:4];
  assign idx    = i_avs_address[3:2];

  function automatic logic [31:0] wpm_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : wpm_merge

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle per request keeps readdata a flop output
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      wait_q <= 1'b1;
    else if (req && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  assign o_avs_waitrequest = wait_q;

  always_comb
  begin
    next_rdata = 32'h0;
    if (i_avs_read && int'(idx) < WP_NUM)
    begin
      case (region)
        `WPM_REG_VAL: next_rdata = watch_address_value[idx] & `WPM_VAL_WMASK;
        `WPM_REG_CTL: next_rdata = watchpoint_control[idx] & `WPM_CTL_WMASK;
        default:      next_rdata = 32'h0;
      endcase
    end
    if (i_avs_read && region == `WPM_REG_IRQ)
    begin
      if (idx == `WPM_IRQ_STAT)
        next_rdata = 32'(irq_status);
      else if (idx == `WPM_IRQ_MASK)
        next_rdata = 32'(irq_mask);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_avs_readdata <= 32'h0;
    else if (req && wait_q)
      o_avs_readdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pair registers and match units
  for (genvar n = 0; n < WP_NUM; n++)
  begin : g_pair
    // enable resets to zero so no event fires before software sets it
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
      if (!i_rstn)
        watchpoint_control[n] <= `WPM_CTL_RST;
      else if (acc_wr && region == `WPM_REG_CTL && int'(idx) == n)
        watchpoint_control[n] <= wpm_merge(watchpoint_control[n], i_avs_writedata,
                                           i_avs_byteenable) & `WPM_CTL_WMASK;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
      if (!i_rstn)
        watch_address_value[n] <= `WPM_VAL_RST;
      else if (acc_wr && region == `WPM_REG_VAL && int'(idx) == n)
        watch_address_value[n] <= wpm_merge(watch_address_value[n], i_avs_writedata,
                                            i_avs_byteenable) & `WPM_VAL_WMASK;
    end

    wpm_match i_wpm_match (
      .i_ref_clk    (i_ref_clk),
      .i_rstn       (i_rstn),
      .i_ctl        (watchpoint_control[n]),
      .i_wvr        (watch_address_value[n]),
      .i_acc_valid  (i_acc_valid),
      .i_acc_addr   (i_acc_addr),
      .i_acc_size   (i_acc_size),
      .i_acc_load   (i_acc_load),
      .i_acc_store  (i_acc_store),
      .i_acc_priv   (i_acc_priv),
      .i_acc_hyp    (i_acc_hyp),
      .i_acc_secure (i_acc_secure),
      .i_ctx_match  (i_ctx_match),
      .o_hit        (hit[n])
    );
  end

  assign o_wp_event = hit;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear; a new hit beats the clear
  assign st_clr = (acc_wr && region == `WPM_REG_IRQ && idx == `WPM_IRQ_STAT &&
                   i_avs_byteenable[0]) ? i_avs_writedata[WP_NUM-1:0] : '0;
  assign next_status = (irq_status & ~st_clr) | hit;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_status <= '0;
    else
      irq_status <= next_status;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_mask <= '0;
    else if (acc_wr && region == `WPM_REG_IRQ && idx == `WPM_IRQ_MASK &&
             i_avs_byteenable[0])
      irq_mask <= i_avs_writedata[WP_NUM-1:0];
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(next_status & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_wait_answer;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("request not answered in one cycle");

  property p_val_raz;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_avs_read && !o_avs_waitrequest && region == `WPM_REG_VAL
      |-> o_avs_readdata[1:0] == 2'h0;
  endproperty
  a_val_raz: assert property (p_val_raz)
    else $error("value register low bits not zero");

  property p_event_stat;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_wp_event[0] |=> irq_status[0];
  endproperty
  a_event_stat: assert property (p_event_stat)
    else $error("event lost from status");

  property p_disabled_quiet;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !watchpoint_control[0][`WPM_EN_BIT] ##1
      !watchpoint_control[0][`WPM_EN_BIT] |-> !o_wp_event[0];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("event from disabled watchpoint");
endmodule : wpm_top
`default_nettype wire

// file: testbench/wpm_lsu_model.sv
// load/store pipeline model that issues one data access per request
`timescale 1ns/10ps
`default_nettype none
module wpm_lsu_model (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // request from the bench
  input  wire logic        i_go,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_size,
  input  wire logic [1:0]  i_kind,
  input  wire logic [2:0]  i_mode,
  input  wire logic [15:0] i_ctx,
  // access port
  output logic             o_acc_valid,
  output logic [31:0]      o_acc_addr,
  output logic [1:0]       o_acc_size,
  output logic             o_acc_load,
  output logic             o_acc_store,
  output logic             o_acc_priv,
  output logic             o_acc_hyp,
  output logic             o_acc_secure,
  output logic [15:0]      o_ctx_match
);
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_acc_valid <= 1'b0;
      o_acc_addr  <= 32'h0000_0000;
    end
    else
    begin
      o_acc_valid <= i_go;
      // idle cycles alternate between the inverted and the last access address
      o_acc_addr  <= i_go ? i_addr : ~o_acc_addr;
    end
  end
  always_ff @(posedge i_ref_clk)
  begin
    o_acc_size   <= i_size;
    o_acc_load   <= i_kind[0];
    o_acc_store  <= i_kind[1];
    {o_acc_priv, o_acc_hyp, o_acc_secure} <= i_mode;
    o_ctx_match  <= i_go ? i_ctx : ~i_ctx;
  end
endmodule : wpm_lsu_model
`default_nettype wire

// file: testbench/wpm_top_tb_top.sv
// self-checking bench of the watchpoint block
`include "wpm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module wpm_top_tb_top;
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, av_read = 1'b0, av_write = 1'b0;
  logic [7:0] av_addr = 8'h00;
  logic [31:0] av_wdata = 32'h0, readdata, r_addr = 32'h0, acc_addr;
  logic [1:0] r_size = 2'h0, r_kind = 2'h1, acc_size;
  logic [2:0] r_mode = 3'h0;
  logic [15:0] r_ctx = 16'h0, ctx;
  logic waitreq, irq, acc_valid, ld, st, pv, hy, sc, pend = 1'b0;
  logic [3:0] wp_event, exp_stat = 4'h0;
  logic [31:0] ctl_sh [4], wvr_sh [4];
  logic [3:0] ev_q [$];
  logic [31:0] rd_q [$];
  int num_errors = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  wpm_lsu_model i_wpm_lsu_model (.i_ref_clk(clk), .i_rstn(rstn), .i_go(go), .i_addr(r_addr),
    .i_size(r_size), .i_kind(r_kind), .i_mode(r_mode), .i_ctx(r_ctx), .o_acc_valid(acc_valid),
    .o_acc_addr(acc_addr), .o_acc_size(acc_size), .o_acc_load(ld), .o_acc_store(st),
    .o_acc_priv(pv), .o_acc_hyp(hy), .o_acc_secure(sc), .o_ctx_match(ctx));
  wpm_top #(.WP_NUM(4)) i_wpm_top (.i_ref_clk(clk), .i_rstn(rstn), .i_avs_address(av_addr),
    .i_avs_read(av_read), .i_avs_write(av_write), .i_avs_writedata(av_wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
    .i_acc_valid(acc_valid), .i_acc_addr(acc_addr), .i_acc_size(acc_size), .i_acc_load(ld),
    .i_acc_store(st), .i_acc_priv(pv), .i_acc_hyp(hy), .i_acc_secure(sc), .i_ctx_match(ctx),
    .o_wp_event(wp_event), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic check_event(input logic [3:0] got, input logic [3:0] exp);
    check({28'h0, got}, {28'h0, exp}, "event");
  endtask : check_event
  task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
    check(got, exp, "read");
  endtask : check_read
  task automatic check_irq(input logic got, input logic exp, input string what);
    check({31'h0, got}, {31'h0, exp}, what);
  endtask : check_irq
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // requests start one edge late so no strobe is assigned twice in a step
  task automatic av_req(input logic [7:0] a, input logic [31:0] d, input logic wr);
    @(posedge clk);
    av_addr <= a;
    av_wdata <= d;
    av_write <= wr;
    av_read <= !wr;
    // the wait for the answer ends when waitreq drops; only the watchdog limits it
    do
      @(posedge clk);
    while (waitreq !== 1'b0);
    av_write <= 1'b0;
    av_read <= 1'b0;
  endtask : av_req
  task automatic av_rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    av_req(a, 32'h0, 1'b0);
  endtask : av_rd
  // own reading of the match rules, mask of 1 or 2 counts as none
  function automatic logic exp_hit(logic [31:0] c, logic [31:0] w, logic [31:0] a,
    logic [1:0] sz, logic [1:0] k, logic [2:0] m, logic [15:0] cx);
    logic ok;
    logic [31:0] l, d;
    logic [4:0] s;
    ok = c[0] & ((c[3] & k[0]) | (c[4] & k[1]));
    ok &= m[1] ? c[13] : (m[2] ? c[1] : c[2]);
    if (c[15:14] == 2'b01) ok &= !m[0];
    else if (c[15:14] == 2'b10) ok &= m[0];
    if (c[20]) ok &= cx[c[19:16]];
    l = a + (32'h1 << sz) - 32'h1;
    s = c[28:24];
    if (s >= `WPM_MSK_MIN)
      return ok & (((a >> s) == (w >> s)) | ((l >> s) == (w >> s)));
    d = a - w;
    // any covered byte within the eight watched lanes
    for (int j = 0; j < 8; j++)
      if (c[5 + j] && (32'(j) - d) < (32'h1 << sz)) return ok;
    return 1'b0;
  endfunction : exp_hit
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (pend && ev_q.size() > 0)
      check_event(wp_event, ev_q.pop_front());
    if (av_read && waitreq === 1'b0 && rd_q.size() > 0)
      check_read(readdata, rd_q.pop_front());
    pend <= acc_valid;
  end
  initial
  begin
    #(25ns * 40000);
    num_errors++;
    end_sim();
  end
  initial
  begin
    logic [3:0] ev;
    logic g;
    void'($urandom(32'hde9f));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    av_rd(8'h10, `WPM_CTL_RST);
    av_req(8'h00, 32'hffff_ffff, 1'b1);
    av_rd(8'h00, `WPM_VAL_WMASK);
    av_req(8'h10, 32'hffff_ffff, 1'b1);
    av_rd(8'h10, `WPM_CTL_WMASK);
    av_req(8'hf0, 32'h1234_5678, 1'b1);
    av_rd(8'hf0, 32'h0);
    for (int ph = 0; ph < 12; ph++)
    begin
      for (int n = 0; n < 4; n++)
      begin
        ctl_sh[n] = $urandom & `WPM_CTL_WMASK;
        ctl_sh[n][4:3] = 2'($urandom_range(1, 3));
        ctl_sh[n][28:24] = (ph % 3 == 0) ? 5'(2 + $urandom_range(1, 4)) : 5'h00;
        if (!ctl_sh[n][20]) ctl_sh[n][19:16] = 4'h0;
        wvr_sh[n] = 32'h1000 | (32'($urandom_range(0, 15)) << 2);
        av_req(8'h00 + 8'(4 * n), wvr_sh[n], 1'b1);
        av_req(8'h10 + 8'(4 * n), ctl_sh[n], 1'b1);
      end
      for (int n = 0; n < 4; n++)
        av_rd(8'h10 + 8'(4 * n), ctl_sh[n]);
      @(posedge clk);
      for (int i = 0; i < 400; i++)
      begin
        g = ($urandom_range(0, 3) != 0);
        r_addr <= 32'h1000 + 32'($urandom_range(0, 71));
        r_size <= 2'($urandom);
        r_kind <= 2'($urandom_range(1, 3));
        r_mode <= 3'($urandom);
        r_ctx <= 16'($urandom);
        go <= g;
        #1;
        for (int n = 0; n < 4; n++)
          ev[n] = exp_hit(ctl_sh[n], wvr_sh[n], r_addr, r_size, r_kind, r_mode, r_ctx);
        if (g) ev_q.push_back(ev);
        if (g) exp_stat |= ev;
        @(posedge clk);
      end
      go <= 1'b0;
      repeat (3) @(posedge clk);
      av_rd(8'h20, {28'h0, exp_stat});
      av_req(8'h24, 32'h0000_000f, 1'b1);
      repeat (2) @(posedge clk);
      check_irq(irq, exp_stat != 4'h0, "irq on");
      av_req(8'h24, 32'h0, 1'b1);
      repeat (2) @(posedge clk);
      check_irq(irq, 1'b0, "irq masked");
      av_req(8'h20, 32'h0000_000f, 1'b1);
      exp_stat = 4'h0;
      av_rd(8'h20, 32'h0);
    end
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : wpm_top_tb_top
`default_nettype wire
